// >>> src/tfp_pkg.sv
// package: register map, field positions and timing for the thermal fan pin control block
package tfp_pkg;
  // ==========================================
  // register byte addresses (wishbone, 32-bit words)
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h8;
  localparam logic [3:0] ADDR_REMOTE = 4'hc;
  localparam logic [3:0] ADDR_ALERT = 4'h0;

  // ==========================================
  // field positions
  localparam int CFG_INT_EN = 1;
  localparam int CFG_GPI_POL = 2;
  localparam int CFG_FAN_STOP = 3;
  localparam int ST_TEMP = 0;
  localparam int ST_NAND = 1;
  localparam int ST_PWR_LOST = 2;
  localparam int ST_AUX_RST = 3;
  localparam int ST_GPI = 4;
  localparam int RF_RESET_PULSE = 0;
  localparam int RF_POWER_OFF = 1;
  localparam int RF_PULSE_BUSY = 2;

  localparam int STATUS_W = 5;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [STATUS_W-1:0] MASK_RESET = 5'h1f;
  localparam logic [7:0] FAN_FULL = 8'hff;
  localparam logic [7:0] FAN_OFF_CODE = 8'h00;

  // ==========================================
  // remote reset pulse width
  localparam int CLOCK_MHZ = 200;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_MHZ) / 1000;
  localparam int PULSE_W = 8;

  typedef enum logic [1:0] {
    TFP_IDLE = 2'b01,
    TFP_PULSE = 2'b10
  } tfp_state_t;

  // pin-side outputs grouped
  typedef struct packed {
    logic fan_stop_oe;
    logic alert_a_oe;
    logic alert_b_oe;
    logic interrupt_oe;
    logic remote_reset_oe;
    logic remote_power_off;
  } tfp_pins_t;
endpackage : tfp_pkg

// >>> src/tfp_thermal_fan_pins.sv
// thermal fan pin control: alerts, fan stop, interrupt, general input, remote reset/power-off, nand test
//
// Function
// R1: open-drain fan stop request pulled low asks fan off, released lets it run.
// R2: general input has programmable polarity; active state sets status bit 4.
// R3: floating general input reads as zero before polarity is applied.
// R4: auxiliary reset input driven low resets the device; the power-off latch, fan output register and bus ack ignore it.
// R5: main power lost low forces fan output off and clears remote power-off.
// R6: remote reset message produces low pulse on open-drain remote reset output.
// R7: power-off message sets output and bit high until power lost goes low.
// R8: temperature violation asserts primary alert low and forces fan full speed.
// R9: second open-drain alert carries the same over-temperature indication.
// R10: high on shared fan pin selects nand test, else pin is fan output.
// R11: in nand test mode the primary alert pin carries the nand tree result.
// R12: interrupt output drives low on violation only when config bit 1 set.
// R13: remote function register controls remote reset and remote power-off.
// R14: interrupt mask register masks each interrupt source individually.
// R15: remote reset pulse lasts a fixed number of clock cycles, then releases.
// R16: second alert follows primary alert in same cycle, unaffected by nand test.
`timescale 1ns/1ps
module tfp_thermal_fan_pins
  import tfp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core-side inputs (same clock)
  input wire logic temp_violation,
  input wire logic [7:0] fan_code,
  input wire logic remote_reset_msg,
  input wire logic remote_off_msg,
  input wire logic nand_tree_result,
  // pins (asynchronous)
  input wire logic general_input,
  input wire logic aux_reset_n,
  input wire logic power_good_n,
  input wire logic nand_test_enable,
  // pin outputs
  output logic [7:0] fan_speed_analog,
  output logic fan_speed_oe,
  output logic fan_stop_n_o,
  output logic fan_stop_n_oe,
  output logic overtemp_alert_a_n_o,
  output logic overtemp_alert_a_n_oe,
  output logic overtemp_alert_b_n_o,
  output logic overtemp_alert_b_n_oe,
  output logic interrupt_n_o,
  output logic interrupt_n_oe,
  output logic remote_reset_n_o,
  output logic remote_reset_n_oe,
  output logic remote_power_off,
  output logic irq
);

  // ==========================================
  // pin synchronisers
  // the pins move at any time; two stages keep a metastable level away from the decoders
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge clock) begin
    sync1 <= {nand_test_enable, power_good_n, aux_reset_n, general_input};
    sync2 <= sync1;
  end
  wire logic gpi_level = sync2[0]; // R3
  wire logic aux_rst_low = ~sync2[1];
  wire logic pwr_lost = ~sync2[2];
  wire logic nand_mode = sync2[3]; // R10

  // auxiliary reset acts like the main one except on the power-off latch, the fan output register and the bus ack; synchronised, so it takes two cycles to bite
  wire logic int_reset = reset | aux_rst_low; // R4

  // ==========================================
  // registers
  logic [7:0] config_reg;
  logic [STATUS_W-1:0] int_status;
  logic [STATUS_W-1:0] int_mask;
  logic power_off_bit;
  tfp_state_t state;
  logic [PULSE_W-1:0] pulse_count;

  wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack high, while address and data still stand;
  // the edge that takes the request only launches the registered answer
  wire logic bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire logic wr_config = bus_wr & (wb_adr_i == ADDR_CONFIG);
  wire logic wr_status = bus_wr & (wb_adr_i == ADDR_INT_STATUS);
  wire logic wr_mask = bus_wr & (wb_adr_i == ADDR_INT_MASK);
  wire logic wr_remote = bus_wr & (wb_adr_i == ADDR_REMOTE);

  // ==========================================
  // general input polarity and event sources
  wire logic gpi_active = gpi_level ^ config_reg[CFG_GPI_POL]; // R2
  logic [STATUS_W-1:0] events;
  assign events[ST_TEMP] = temp_violation;
  assign events[ST_NAND] = nand_mode;
  assign events[ST_PWR_LOST] = pwr_lost;
  assign events[ST_AUX_RST] = 1'b0;
  assign events[ST_GPI] = gpi_active; // R2

  // set wins over write-one-to-clear
  logic [STATUS_W-1:0] clr_bits;
  assign clr_bits = wr_status ? wb_dat_i[STATUS_W-1:0] : '0;
  wire logic [STATUS_W-1:0] next_status = (int_status & ~clr_bits) | events;

  // remote triggers: bus message or register write
  wire logic pulse_req = remote_reset_msg | (wr_remote & wb_dat_i[RF_RESET_PULSE]); // R6 R13
  wire logic off_req = remote_off_msg | (wr_remote & wb_dat_i[RF_POWER_OFF]); // R7 R13

  always_ff @(posedge clock) begin
    if (int_reset) begin
      config_reg <= CONFIG_RESET; // R12
      int_status <= '0;
      int_mask <= MASK_RESET;
    end else begin
      if (wr_config) begin
        config_reg <= wb_dat_i[7:0];
      end
      if (wr_mask) begin
        int_mask <= wb_dat_i[STATUS_W-1:0]; // R14
      end
      int_status <= next_status;
    end
  end

  // power-off latch survives the aux reset; only the main reset or power loss clears it
  always_ff @(posedge clock) begin
    if (reset | pwr_lost) begin
      power_off_bit <= 1'b0; // R5 R7
    end else if (off_req) begin
      power_off_bit <= 1'b1; // R7
    end
  end

  // ==========================================
  // remote reset pulse
  always_ff @(posedge clock) begin
    if (int_reset) begin
      state <= TFP_IDLE;
      pulse_count <= '0;
    end else begin
      case (state)
        TFP_IDLE: begin
          if (pulse_req) begin
            state <= TFP_PULSE; // R6
            pulse_count <= PULSE_W'(PULSE_CYCLES - 1);
          end
        end
        TFP_PULSE: begin
          if (pulse_count == '0) begin
            state <= TFP_IDLE; // R15
          end else begin
            pulse_count <= pulse_count - 1'b1;
          end
        end
        default: state <= TFP_IDLE;
      endcase
    end
  end

  // ==========================================
  // read mux and ack
  wire logic [31:0] rd_config = {24'h0, config_reg};
  wire logic [31:0] rd_status = {27'h0, int_status};
  wire logic [31:0] rd_mask = {27'h0, int_mask};
  // the start bit reads back as zero: it is a strobe, the busy flag shows the pulse instead
  logic [31:0] rd_remote;
  always_comb begin
    rd_remote = 32'h0;
    rd_remote[RF_POWER_OFF] = power_off_bit; // R7 R13
    rd_remote[RF_PULSE_BUSY] = (state == TFP_PULSE); // R13
  end
  wire logic [31:0] rd_data = (wb_adr_i == ADDR_CONFIG) ? rd_config :
                              (wb_adr_i == ADDR_INT_STATUS) ? rd_status :
                              (wb_adr_i == ADDR_INT_MASK) ? rd_mask :
                              (wb_adr_i == ADDR_REMOTE) ? rd_remote : 32'h0;

  always_ff @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0;
    end
  end

  // ==========================================
  // pin outputs
  wire logic pending = |(int_status & ~int_mask);
  wire logic alert_on = temp_violation; // R8

  always_ff @(posedge clock) begin
    if (reset | pwr_lost) begin
      fan_speed_analog <= FAN_OFF_CODE; // R5
    end else if (alert_on) begin
      fan_speed_analog <= FAN_FULL; // R8
    end else begin
      fan_speed_analog <= fan_code;
    end
  end

  assign fan_speed_oe = ~nand_mode; // R10

  // pin controls travel together; every open-drain pin except the primary alert in nand mode only ever pulls to zero
  // the fan stop request gives way while the alert forces the fan to full speed
  tfp_pins_t pin_ctl;
  always_comb begin
    pin_ctl = '0;
    pin_ctl.fan_stop_oe = config_reg[CFG_FAN_STOP] & ~alert_on; // R1
    pin_ctl.alert_a_oe = nand_mode | alert_on; // R8 R11
    pin_ctl.alert_b_oe = alert_on; // R9 R16
    pin_ctl.interrupt_oe = config_reg[CFG_INT_EN] & pending; // R12 R14
    pin_ctl.remote_reset_oe = (state == TFP_PULSE); // R6
    pin_ctl.remote_power_off = power_off_bit; // R7
  end

  assign fan_stop_n_o = 1'b0;
  assign fan_stop_n_oe = pin_ctl.fan_stop_oe; // R1
  // nand mode drives the result actively, since it is a test output
  assign overtemp_alert_a_n_o = nand_mode ? nand_tree_result : 1'b0; // R11
  assign overtemp_alert_a_n_oe = pin_ctl.alert_a_oe; // R8 R11
  assign overtemp_alert_b_n_o = 1'b0;
  assign overtemp_alert_b_n_oe = pin_ctl.alert_b_oe; // R9 R16
  assign interrupt_n_o = 1'b0;
  assign interrupt_n_oe = pin_ctl.interrupt_oe; // R12 R14
  assign remote_reset_n_o = 1'b0;
  assign remote_reset_n_oe = pin_ctl.remote_reset_oe; // R6
  assign remote_power_off = pin_ctl.remote_power_off; // R7
  assign irq = pending;

  // ==========================================
  // assertions
  a_int_gated: assert property (@(posedge clock) disable iff (reset)
    !config_reg[CFG_INT_EN] |-> !interrupt_n_oe) // R12
    else $error("interrupt driven while disabled");

  a_alert_twin: assert property (@(posedge clock) disable iff (reset)
    overtemp_alert_b_n_oe == temp_violation) // R16
    else $error("second alert not in step");

  a_alert_full_fan: assert property (@(posedge clock) disable iff (reset)
    temp_violation && !pwr_lost |=> fan_speed_analog == FAN_FULL) // R8
    else $error("fan not full on alert");

  a_pwr_lost_off: assert property (@(posedge clock) disable iff (reset)
    pwr_lost |=> !remote_power_off && fan_speed_analog == FAN_OFF_CODE) // R5
    else $error("power loss did not clear outputs");

  a_off_latched: assert property (@(posedge clock) disable iff (reset)
    remote_power_off && !pwr_lost |=> remote_power_off) // R7
    else $error("power-off dropped early");

  sequence s_pulse_start;
    !int_reset && state == TFP_IDLE && pulse_req;
  endsequence
  a_pulse_width: assert property (@(posedge clock) disable iff (int_reset)
    s_pulse_start |=> remote_reset_n_oe [*8]) // R6 R15
    else $error("remote reset pulse too short");

  a_pulse_ends: assert property (@(posedge clock) disable iff (int_reset)
    $rose(remote_reset_n_oe) |-> ##[1:300] !remote_reset_n_oe) // R15
    else $error("remote reset pulse never ends");

  a_gpi_sets: assert property (@(posedge clock) disable iff (int_reset)
    gpi_active |=> int_status[ST_GPI]) // R2
    else $error("general input did not set status");

  a_nand_alert: assert property (@(posedge clock) disable iff (reset)
    nand_mode |-> overtemp_alert_a_n_oe && overtemp_alert_a_n_o == nand_tree_result) // R11
    else $error("nand result not on alert pin");

  a_mask_gates: assert property (@(posedge clock) disable iff (reset)
    (int_status & ~int_mask) == '0 |-> !interrupt_n_oe && !irq) // R14
    else $error("masked source reached interrupt");

  a_fan_stop_yield: assert property (@(posedge clock) disable iff (reset)
    alert_on |-> !fan_stop_n_oe) // R1
    else $error("fan stop request held during alert");

  a_fan_stop_drive: assert property (@(posedge clock) disable iff (reset)
    config_reg[CFG_FAN_STOP] && !alert_on |-> fan_stop_n_oe && !fan_stop_n_o) // R1
    else $error("fan stop request not driven");

  a_alert_a_drive: assert property (@(posedge clock) disable iff (reset)
    !nand_mode |-> overtemp_alert_a_n_oe == temp_violation && !overtemp_alert_a_n_o) // R8
    else $error("primary alert not in step");

  a_fan_pin_mode: assert property (@(posedge clock) disable iff (reset)
    fan_speed_oe == !nand_mode) // R10
    else $error("fan pin direction wrong");

  a_int_raise: assert property (@(posedge clock) disable iff (reset)
    config_reg[CFG_INT_EN] && pending |-> interrupt_n_oe && !interrupt_n_o) // R12
    else $error("enabled interrupt not driven");

  a_off_request: assert property (@(posedge clock) disable iff (reset)
    off_req && !pwr_lost |=> remote_power_off) // R7
    else $error("power-off request not latched");

  a_fan_follows: assert property (@(posedge clock) disable iff (reset)
    !temp_violation && !pwr_lost |=> fan_speed_analog == $past(fan_code)) // R8
    else $error("fan code not passed through");

  sequence s_bus_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_answer: assert property (@(posedge clock) disable iff (reset)
    s_bus_taken |=> s_bus_answer) // R13
    else $error("bus request not answered in one cycle");

  // every status source is sticky: an event is never lost to a clear in the same cycle
  for (genvar b = 0; b < STATUS_W; b++) begin : g_status_check
    a_status_set: assert property (@(posedge clock) disable iff (int_reset)
      events[b] |=> int_status[b]) // R2 R14
      else $error("status event lost");
    a_status_hold: assert property (@(posedge clock) disable iff (int_reset)
      int_status[b] && !clr_bits[b] |=> int_status[b]) // R14
      else $error("status bit dropped without a clear");
  end

  a_pulse_busy: assert property (@(posedge clock) disable iff (int_reset)
    state == TFP_PULSE && pulse_count != '0 |=> state == TFP_PULSE) // R6
    else $error("remote reset pulse cut short");

  // helper: counts how long the remote reset pin has been held, so the whole width is checked
  logic [PULSE_W-1:0] pulse_seen;
  always_ff @(posedge clock) begin
    if (int_reset | ~remote_reset_n_oe) begin
      pulse_seen <= '0;
    end else begin
      pulse_seen <= pulse_seen + 1'b1;
    end
  end

  a_pulse_exact: assert property (@(posedge clock) disable iff (int_reset)
    $fell(remote_reset_n_oe) && !$past(int_reset) |-> pulse_seen == PULSE_W'(PULSE_CYCLES)) // R15
    else $error("remote reset pulse width wrong");
endmodule : tfp_thermal_fan_pins

// >>> tb/tfp_far_side.sv
// far-side model: system power circuitry and board pins around the block
`timescale 1ns/1ps
module tfp_far_side (
  input wire logic gpi_float,
  input wire logic gpi_level,
  input wire logic power_lost,
  input wire logic aux_low,
  input wire logic test_sel,
  output logic general_input,
  output logic power_good_n,
  output logic aux_reset_n,
  output logic nand_test_enable
);
  // ==========================================
  // pin levels
  // an open general input is seen as a weak pull-down
  assign general_input = gpi_float ? 1'b0 : gpi_level;
  assign power_good_n = !power_lost;
  assign aux_reset_n = !aux_low;
  assign nand_test_enable = test_sel;
endmodule : tfp_far_side

// >>> tb/tfp_thermal_fan_pins_test.sv
// self-checking bench for the thermal fan pin control block
`timescale 1ns/1ps
module tfp_thermal_fan_pins_test;
  import tfp_pkg::*;
  logic clock = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic temp_violation = 1'b0, remote_reset_msg = 1'b0, remote_off_msg = 1'b0, nand_tree_result = 1'b0;
  logic gf = 1'b1, gl = 1'b0, pl = 1'b0, al = 1'b0, ts = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [7:0] fan_code = 8'h0, fan_speed_analog;
  logic wb_ack_o, general_input, aux_reset_n, power_good_n, nand_test_enable, fan_speed_oe;
  logic fan_stop_n_o, fan_stop_n_oe, overtemp_alert_a_n_o, overtemp_alert_a_n_oe, overtemp_alert_b_n_o;
  logic overtemp_alert_b_n_oe, interrupt_n_o, interrupt_n_oe, remote_reset_n_o, remote_reset_n_oe;
  logic remote_power_off, irq;
  int err_total = 0, compares = 0, cycles = 0, n;
  integer seed = 32'h444c;

  tfp_far_side i_tfp_far_side (.gpi_float(gf), .gpi_level(gl), .power_lost(pl), .aux_low(al), .test_sel(ts),
    .general_input, .power_good_n, .aux_reset_n, .nand_test_enable);
  tfp_thermal_fan_pins i_tfp_thermal_fan_pins (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .temp_violation, .fan_code, .remote_reset_msg, .remote_off_msg,
    .nand_tree_result, .general_input, .aux_reset_n, .power_good_n, .nand_test_enable, .fan_speed_analog,
    .fan_speed_oe, .fan_stop_n_o, .fan_stop_n_oe, .overtemp_alert_a_n_o, .overtemp_alert_a_n_oe,
    .overtemp_alert_b_n_o, .overtemp_alert_b_n_oe, .interrupt_n_o, .interrupt_n_oe, .remote_reset_n_o,
    .remote_reset_n_oe, .remote_power_off, .irq);

  // ==========================================
  // clock, timeout, helpers
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  // entered just after an edge; the ack edge is the only place data is taken
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  function automatic logic [31:0] gpi_exp(input logic pol, input logic lvl);
    return {27'h0, lvl ^ pol, 4'h0};
  endfunction : gpi_exp

  function automatic logic [7:0] fan_exp(input logic hot, input logic lost, input logic [7:0] c);
    return lost ? FAN_OFF_CODE : (hot ? FAN_FULL : c);
  endfunction : fan_exp

  // ==========================================
  // main sequence
  initial begin
    tick(3);
    reset <= 1'b0;
    tick(3);
    wb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config", q, {24'h0, CONFIG_RESET});
    wb(1'b0, ADDR_INT_MASK, 32'h0);
    chk("mask", q, {27'h0, MASK_RESET});
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 24; i++) begin
      fan_code <= 8'($random(seed));
      temp_violation <= 1'($random(seed));
      tick(3);
      chk("fan", fan_speed_analog, fan_exp(temp_violation, 1'b0, fan_code));
      chk("alert_a", {overtemp_alert_a_n_oe, overtemp_alert_a_n_o}, {temp_violation, 1'b0});
      chk("alert_b", {overtemp_alert_b_n_oe, overtemp_alert_b_n_o}, {temp_violation, 1'b0});
    end
    temp_violation <= 1'b1;
    wb(1'b1, ADDR_CONFIG, 32'h2);
    chk("irq_masked", {irq, interrupt_n_oe}, 2'b00);
    wb(1'b1, ADDR_INT_MASK, 32'h1e);
    chk("irq_on", {irq, interrupt_n_oe, interrupt_n_o}, 3'b110);
    wb(1'b1, ADDR_CONFIG, 32'h8);
    chk("int_off", {irq, interrupt_n_oe}, 2'b10);
    temp_violation <= 1'b0;
    tick(1);
    chk("fan_stop", {fan_stop_n_oe, fan_stop_n_o}, 2'b10);
    wb(1'b1, ADDR_INT_STATUS, 32'h1);
    chk("irq_clear", irq, 1'b0);
    for (int k = 0; k < 4; k++) begin
      gf <= ~k[0];
      gl <= 1'b1;
      wb(1'b1, ADDR_CONFIG, {29'h0, k[1], 2'b00});
      tick(4);
      wb(1'b1, ADDR_INT_STATUS, 32'h10);
      tick(4);
      wb(1'b0, ADDR_INT_STATUS, 32'h0);
      chk("gpi", q & 32'h10, gpi_exp(k[1], k[0]));
    end
    ts <= 1'b1;
    tick(4);
    for (int i = 0; i < 6; i++) begin
      nand_tree_result <= 1'($random(seed));
      temp_violation <= 1'($random(seed));
      tick(1);
      chk("nand_out", {fan_speed_oe, overtemp_alert_a_n_oe, overtemp_alert_a_n_o}, {2'b01, nand_tree_result});
      chk("nand_b", {overtemp_alert_b_n_oe, overtemp_alert_b_n_o}, {temp_violation, 1'b0});
    end
    ts <= 1'b0;
    temp_violation <= 1'b0;
    tick(4);
    chk("fan_pin", fan_speed_oe, 1'b1);
    remote_reset_msg <= 1'b1;
    tick(1);
    n = 0;
    for (int i = 0; i < 300; i++) begin
      remote_reset_msg <= (i == 60);
      @(posedge clock);
      n += int'(remote_reset_n_oe === 1'b1 && remote_reset_n_o === 1'b0);
    end
    chk("pulse_len", n, PULSE_CYCLES);
    wb(1'b1, ADDR_REMOTE, 32'h1);
    wb(1'b0, ADDR_REMOTE, 32'h0);
    chk("busy", {q[2], remote_reset_n_oe}, 2'b11);
    tick(PULSE_CYCLES);
    wb(1'b0, ADDR_REMOTE, 32'h0);
    chk("idle", {q[2], remote_reset_n_oe}, 2'b00);
    remote_off_msg <= 1'b1;
    tick(1);
    remote_off_msg <= 1'b0;
    tick(50);
    wb(1'b0, ADDR_REMOTE, 32'h0);
    chk("poff", {q[1], remote_power_off}, 2'b11);
    fan_code <= 8'h5a;
    pl <= 1'b1;
    tick(5);
    chk("lost", {remote_power_off, fan_speed_analog}, {1'b0, fan_exp(1'b0, 1'b1, 8'h5a)});
    pl <= 1'b0;
    tick(4);
    wb(1'b1, ADDR_REMOTE, 32'h2);
    wb(1'b1, ADDR_CONFIG, 32'ha);
    al <= 1'b1;
    tick(4);
    al <= 1'b0;
    tick(4);
    wb(1'b0, ADDR_CONFIG, 32'h0);
    chk("aux_rst", {q, remote_power_off}, {32'h0, 1'b1});
    give_verdict();
  end
endmodule : tfp_thermal_fan_pins_test
